/* File: include/rst_timer_pkg.sv */
// Shared constants, types and register map of the reset timer sequencer
package rst_timer_pkg;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 200;       // Core clock rate in MHz
    localparam int unsigned CNT_W              = 32;        // Width of the delay counter

    // ------------------------------------------------------------
    // Delays in microseconds, as specified
    // ------------------------------------------------------------
    localparam int unsigned TURN_ON_US         = 1_900_000; // Long power-on hold, 1.9 s
    localparam int unsigned TURN_ON_FAST_US    = 10_000;    // Short power-on hold, 10 ms
    localparam int unsigned RESET_HOLD_US      = 7_700_000; // Long reset hold, 7.7 s
    localparam int unsigned RESET_HOLD_FAST_US = 2_000;     // Factory-test reset hold, 2 ms
    localparam int unsigned RESET_PULSE_US     = 468_000;   // Switch-off pulse, 468 ms
    localparam int unsigned SD_LONG_US         = 7_700_000; // Delayed turn-off, 7.7 s
    localparam int unsigned SD_SHORT_US        = 2_000;     // Zero-second turn-off, 2 ms
    localparam int unsigned QUALIFY_US         = 2_000;     // Shutdown request qualification, 2 ms

    // ------------------------------------------------------------
    // Delays in clock cycles (exact: whole microseconds times MHz)
    // ------------------------------------------------------------
    localparam int unsigned TURN_ON_CYC         = TURN_ON_US * CLK_MHZ;
    localparam int unsigned TURN_ON_FAST_CYC    = TURN_ON_FAST_US * CLK_MHZ;
    localparam int unsigned RESET_HOLD_CYC      = RESET_HOLD_US * CLK_MHZ;
    localparam int unsigned RESET_HOLD_FAST_CYC = RESET_HOLD_FAST_US * CLK_MHZ;
    localparam int unsigned RESET_PULSE_CYC     = RESET_PULSE_US * CLK_MHZ;
    localparam int unsigned SD_LONG_CYC         = SD_LONG_US * CLK_MHZ;
    localparam int unsigned SD_SHORT_CYC        = SD_SHORT_US * CLK_MHZ;
    localparam int unsigned QUALIFY_CYC         = QUALIFY_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  CTRL_OFS        = 8'h00;      // Control, read/write
    localparam logic [7:0]  STATUS_OFS      = 8'h04;      // Status, read only
    localparam int unsigned CTRL_TEST_BIT   = 0;          // Allow factory-test shortcut
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam int unsigned ST_SWITCH_BIT   = 0;          // Load switch closed
    localparam int unsigned ST_DISCH_BIT    = 1;          // Discharge pull-down on
    localparam int unsigned ST_ARMED_BIT    = 2;          // Reset press detection armed
    localparam int unsigned ST_TEST_BIT     = 3;          // Factory-test mode latched
    localparam int unsigned ST_HOLD_BIT     = 4;          // Reset hold being timed
    localparam int unsigned ST_QUAL_BIT     = 5;          // Shutdown request being qualified
    localparam int unsigned ST_STATE_LSB    = 8;          // Sequencer state, 3 bits
    localparam int unsigned ST_INPUT_LSB    = 16;         // Synchronised inputs, 5 bits

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic power_key_n;       // Power key, low when pressed
        logic wake_request;      // Wake request
        logic shutdown_request;  // Shutdown request
        logic delay_select;      // Delay-select strap
        logic discharged;        // Output below discharged_threshold
    } in_type;

    localparam in_type IN_RESET = '{power_key_n: 1'b1, default: 1'b0};

    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_RESET_OFF,
        ST_WAIT_DIS,
        ST_SHUTDOWN
    } state_type;

endpackage

/* File: logic/input_sync.sv */
// Two-stage synchroniser for a group of level inputs
module input_sync #(
    parameter int unsigned      WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    // Reset to the idle level so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: logic/delay_timer.sv */
// Down-counter that measures one delay at a time
module delay_timer #(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // State
    output logic      [W-1:0] remain,
    output logic              expired
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Counts down to zero and rests there until reloaded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= load_val;
        end else if (remain != '0) begin
            remain <= remain - W'(1);
        end
    end

    // Zero means the last loaded delay has run out
    assign expired = (remain == '0);

endmodule

/* File: logic/reset_timer_load_switch_ctrl.sv */
// Load switch sequencer: power-on, long-press reset and delayed turn-off
//
// Implementation choices: register access over APB and the placing of the registers.
module reset_timer_load_switch_ctrl #(
    parameter int unsigned TURN_ON_CYC         = rst_timer_pkg::TURN_ON_CYC,
    parameter int unsigned TURN_ON_FAST_CYC    = rst_timer_pkg::TURN_ON_FAST_CYC,
    parameter int unsigned RESET_HOLD_CYC      = rst_timer_pkg::RESET_HOLD_CYC,
    parameter int unsigned RESET_HOLD_FAST_CYC = rst_timer_pkg::RESET_HOLD_FAST_CYC,
    parameter int unsigned RESET_PULSE_CYC     = rst_timer_pkg::RESET_PULSE_CYC,
    parameter int unsigned SD_LONG_CYC         = rst_timer_pkg::SD_LONG_CYC,
    parameter int unsigned SD_SHORT_CYC        = rst_timer_pkg::SD_SHORT_CYC,
    parameter int unsigned QUALIFY_CYC         = rst_timer_pkg::QUALIFY_CYC
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // Pins from the power key and host
    input  wire logic        POWER_KEY_N,
    input  wire logic        WAKE_REQUEST,
    input  wire logic        SHUTDOWN_REQUEST,
    input  wire logic        DELAY_SELECT,
    input  wire logic        DISCHARGED,
    // Switch control
    output logic             SWITCH_ON,
    output logic             DISCHARGE_EN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic [31:0]      PRDATA,
    output logic             PSLVERR
);

    localparam int unsigned W = rst_timer_pkg::CNT_W;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rst_timer_pkg::in_type    in_raw;       // Pins as a group
    rst_timer_pkg::in_type    in_s;         // Synchronised pins
    rst_timer_pkg::state_type state_q;      // Sequencer state
    rst_timer_pkg::state_type state_d;
    logic          key_prev_q;              // Key level last cycle
    logic          shut_prev_q;             // Shutdown level last cycle
    logic          armed_q, armed_d;        // Reset press detection enabled
    logic          hold_q, hold_d;          // Reset hold being timed
    logic          on_act_q, on_act_d;      // Power-on hold being timed
    logic          qual_q, qual_d;          // Shutdown request qualifying
    logic          test_q, test_d;          // Factory-test mode
    logic          long_q, long_d;          // Delayed (abortable) turn-off
    logic          tmr_load;                // Start a new delay
    logic [W-1:0]  tmr_val;                 // Delay to start
    logic [W-1:0]  tmr_remain;              // Cycles left
    logic          tmr_done;                // Delay ran out
    logic [31:0]   ctrl_q;                  // Control register
    logic          switch_d;                // Next switch level
    wire           key_fall  = key_prev_q & ~in_s.power_key_n;
    wire           shut_rise = ~shut_prev_q & in_s.shutdown_request;
    wire           test_ok   = ctrl_q[rst_timer_pkg::CTRL_TEST_BIT];

    // ------------------------------------------------------------
    // Input synchronisers and timebase
    // ------------------------------------------------------------
    assign in_raw = '{power_key_n: POWER_KEY_N, wake_request: WAKE_REQUEST,
                      shutdown_request: SHUTDOWN_REQUEST, delay_select: DELAY_SELECT,
                      discharged: DISCHARGED};

    // Every pin is asynchronous to the core clock
    input_sync #(
        .WIDTH   ($bits(rst_timer_pkg::in_type)),
        .RST_VAL (rst_timer_pkg::IN_RESET)
    ) u_sync (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .async_in (in_raw),
        .sync_out (in_s)
    );

    // One counter serves every delay; phases never overlap
    delay_timer #(
        .W (W)
    ) u_timer (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .load     (tmr_load),
        .load_val (tmr_val),
        .remain   (tmr_remain),
        .expired  (tmr_done)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        armed_d  = armed_q;
        hold_d   = hold_q;
        on_act_d = on_act_q;
        qual_d   = qual_q;
        test_d   = test_q;
        long_d   = long_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        case (state_q)
            // Switch open, waiting for a power-on request
            rst_timer_pkg::ST_OFF: begin
                if (!in_s.power_key_n) begin
                    // Key outranks wake while pressed
                    if (key_fall) begin
                        on_act_d = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val  = in_s.delay_select ? W'(TURN_ON_CYC) : W'(TURN_ON_FAST_CYC);
                    end else if (on_act_q && tmr_done) begin
                        state_d  = rst_timer_pkg::ST_ON;
                        on_act_d = 1'b0;
                        armed_d  = 1'b0;
                    end
                end else begin
                    on_act_d = 1'b0;
                    if (in_s.wake_request) begin
                        state_d = rst_timer_pkg::ST_ON;
                        armed_d = 1'b1;
                    end
                end
            end
            // Switch closed: watch reset press and shutdown request
            rst_timer_pkg::ST_ON: begin
                if (in_s.power_key_n) begin
                    armed_d = 1'b1;
                    hold_d  = 1'b0;
                    if (qual_q) begin
                        if (!in_s.shutdown_request) begin
                            qual_d = 1'b0;
                        end else if (tmr_done) begin
                            qual_d   = 1'b0;
                            state_d  = rst_timer_pkg::ST_SHUTDOWN;
                            long_d   = in_s.delay_select;
                            tmr_load = 1'b1;
                            tmr_val  = in_s.delay_select ? W'(SD_LONG_CYC) : W'(SD_SHORT_CYC);
                        end
                    end else if (shut_rise && !in_s.wake_request) begin
                        // Only a fresh rise starts qualification
                        qual_d   = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val  = W'(QUALIFY_CYC);
                    end
                end else begin
                    qual_d = 1'b0;
                    if (key_fall && armed_q) begin
                        hold_d   = 1'b1;
                        test_d   = ~in_s.delay_select & test_ok;
                        tmr_load = 1'b1;
                        tmr_val  = (!in_s.delay_select && test_ok) ? W'(RESET_HOLD_FAST_CYC)
                                                                   : W'(RESET_HOLD_CYC);
                    end else if (hold_q && tmr_done) begin
                        hold_d   = 1'b0;
                        state_d  = rst_timer_pkg::ST_RESET_OFF;
                        tmr_load = 1'b1;
                        tmr_val  = W'(RESET_PULSE_CYC);
                    end
                end
            end
            // Switch open for the fixed pulse
            rst_timer_pkg::ST_RESET_OFF: begin
                if (tmr_done) begin
                    armed_d = 1'b0;
                    test_d  = 1'b0;
                    state_d = in_s.discharged ? rst_timer_pkg::ST_ON : rst_timer_pkg::ST_WAIT_DIS;
                end
            end
            // Pulse over, output still charged
            rst_timer_pkg::ST_WAIT_DIS: begin
                if (in_s.discharged) begin
                    state_d = rst_timer_pkg::ST_ON;
                end
            end
            // Turn-off countdown
            rst_timer_pkg::ST_SHUTDOWN: begin
                if (long_q && (!in_s.power_key_n || in_s.wake_request)) begin
                    state_d = rst_timer_pkg::ST_ON;
                    armed_d = in_s.power_key_n;
                end else if (tmr_done) begin
                    state_d = rst_timer_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = rst_timer_pkg::ST_OFF;
            end
        endcase
    end

    // Switch is closed while on or counting down to turn-off
    assign switch_d = (state_d == rst_timer_pkg::ST_ON) || (state_d == rst_timer_pkg::ST_SHUTDOWN);

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    // Reset leaves the switch closed and every flag clear
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q  <= rst_timer_pkg::ST_ON;
            armed_q  <= 1'b0;
            hold_q   <= 1'b0;
            on_act_q <= 1'b0;
            qual_q   <= 1'b0;
            test_q   <= 1'b0;
            long_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            armed_q  <= armed_d;
            hold_q   <= hold_d;
            on_act_q <= on_act_d;
            qual_q   <= qual_d;
            test_q   <= test_d;
            long_q   <= long_d;
        end
    end

    // Edge history and pin outputs
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_prev_q   <= 1'b1;
            shut_prev_q  <= 1'b0;
            SWITCH_ON    <= 1'b1;
            DISCHARGE_EN <= 1'b0;
        end else begin
            key_prev_q   <= in_s.power_key_n;
            shut_prev_q  <= in_s.shutdown_request;
            SWITCH_ON    <= switch_d;
            DISCHARGE_EN <= (state_d == rst_timer_pkg::ST_RESET_OFF);
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Access phase takes two cycles: first edge prepares, second completes
    wire        apb_access = PSEL & PENABLE;
    wire        hit_ctrl   = (PADDR == rst_timer_pkg::CTRL_OFS);
    wire        hit_status = (PADDR == rst_timer_pkg::STATUS_OFS);
    wire        apb_err    = ~(hit_ctrl | hit_status);
    wire        ctrl_wr    = apb_access & PREADY & PWRITE & hit_ctrl;
    wire [31:0] status_word;

    // Live view of the sequencer for software
    assign status_word = {11'h000, in_s, 5'h00, state_q, 2'h0, qual_q, hold_q, test_q,
                          armed_q, DISCHARGE_EN, SWITCH_ON};

    // Ready pulses one cycle; data and error settle with it
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= apb_access & ~PREADY;
            PSLVERR <= apb_access & ~PREADY & apb_err;
            if (apb_access && !PREADY && !PWRITE) begin
                PRDATA <= hit_ctrl ? ctrl_q : (hit_status ? status_word : 32'h0000_0000);
            end
        end
    end

    // Writes land on the completing edge only; status is read only
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= rst_timer_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= {31'h0000_0000, PWDATA[rst_timer_pkg::CTRL_TEST_BIT]};
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    AST_DISCH_ONLY_OPEN: assert property (DISCHARGE_EN |-> !SWITCH_ON && state_q == rst_timer_pkg::ST_RESET_OFF)
        else $error("Discharge on while not in reset pulse");
    AST_KEY_POWERON_DISARMED: assert property (
        (state_q == rst_timer_pkg::ST_OFF && !in_s.power_key_n && on_act_q && tmr_done && !key_fall)
        |=> state_q == rst_timer_pkg::ST_ON && !armed_q && SWITCH_ON)
        else $error("Key power-on left reset armed");
    AST_RELEASE_ARMS: assert property (
        (state_q == rst_timer_pkg::ST_ON && in_s.power_key_n) |=> armed_q && !hold_q)
        else $error("Key release did not arm reset");
    AST_HOLD_TO_PULSE: assert property (
        (state_q == rst_timer_pkg::ST_ON && hold_q && !in_s.power_key_n && tmr_done && !key_fall)
        |=> DISCHARGE_EN && !SWITCH_ON && tmr_remain == W'(RESET_PULSE_CYC))
        else $error("Expired hold did not start reset pulse");
    AST_WAIT_DISCHARGE: assert property (
        (state_q == rst_timer_pkg::ST_WAIT_DIS && !in_s.discharged) |=> !SWITCH_ON)
        else $error("Switch reconnected before discharge");
    AST_EARLY_RELEASE: assert property (
        (state_q == rst_timer_pkg::ST_ON && hold_q && in_s.power_key_n) |=> SWITCH_ON && !hold_q ##1 SWITCH_ON)
        else $error("Early release still led to reset");
    AST_ABORT_TURNOFF: assert property (
        (state_q == rst_timer_pkg::ST_SHUTDOWN && long_q && in_s.wake_request)
        |=> state_q == rst_timer_pkg::ST_ON && SWITCH_ON)
        else $error("Delayed turn-off not aborted");
    AST_SHORT_TURNOFF: assert property (
        (state_q == rst_timer_pkg::ST_ON && qual_q && in_s.power_key_n && in_s.shutdown_request
         && tmr_done && !in_s.delay_select)
        |=> tmr_remain == W'(SD_SHORT_CYC) && state_q == rst_timer_pkg::ST_SHUTDOWN)
        else $error("Zero-second turn-off used wrong delay");
    AST_KEY_OVER_SHUTDOWN: assert property (
        (state_q == rst_timer_pkg::ST_ON && !in_s.power_key_n) |=> !qual_q)
        else $error("Shutdown qualified while key pressed");
    AST_APB_ONE_CYCLE: assert property (PREADY |=> !PREADY)
        else $error("Ready held longer than one cycle");

    COV_RESET_PULSE: cover property (DISCHARGE_EN ##1 !DISCHARGE_EN && SWITCH_ON);
    COV_WAIT_DIS: cover property (state_q == rst_timer_pkg::ST_WAIT_DIS ##1 SWITCH_ON);
    COV_LONG_OFF: cover property (state_q == rst_timer_pkg::ST_SHUTDOWN && long_q ##1 !SWITCH_ON);
    COV_WAKE_ON: cover property (state_q == rst_timer_pkg::ST_OFF && in_s.wake_request ##1 SWITCH_ON);

endmodule

/* File: verification/rail_model.sv */
// Far-side rail model: the output discharges only while the switch is open
module rail_model #(
    parameter int FALL = 20  // Cycles until the rail reads discharged
) (
    input  wire logic CLK,
    input  wire logic SW_ON,
    input  wire logic HOLD,  // Keeps the rail charged to act as a slow load
    output logic      DIS
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;  // Cycles since the switch opened
    // The rail decays only while the switch is open
    always @(posedge CLK) cnt <= SW_ON ? 0 : cnt + 1;
    assign DIS = !SW_ON && !HOLD && cnt >= FALL;
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the load switch sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, key_n, wake, shut, dsel, dis, slow, sw, den, psel, pen, pwr, rdy, err, e;
    logic [7:0]  paddr;
    logic [31:0] pwd, prd, rd, seed;
    int          fail_count = 0;
    int          total_checks = 0;
    reset_timer_load_switch_ctrl #(.TURN_ON_CYC(40), .TURN_ON_FAST_CYC(10), .RESET_HOLD_CYC(60),
        .RESET_HOLD_FAST_CYC(8), .RESET_PULSE_CYC(30), .SD_LONG_CYC(50), .SD_SHORT_CYC(12),
        .QUALIFY_CYC(6)) dut (.CORE_CLK(clk), .RST_N(rst_n), .POWER_KEY_N(key_n), .WAKE_REQUEST(wake),
        .SHUTDOWN_REQUEST(shut), .DELAY_SELECT(dsel), .DISCHARGED(dis), .SWITCH_ON(sw),
        .DISCHARGE_EN(den), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
        .PREADY(rdy), .PRDATA(prd), .PSLVERR(err));
    rail_model #(.FALL(20)) far (.CLK(clk), .SW_ON(sw), .HOLD(slow), .DIS(dis));
    // Random source for press lengths and write data
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; request held until the edge that samples ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // Ready is looked at on each rising edge; data taken at the same edge
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            fail_count++;
            final_report();
        end
        rd = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst_n, wake, shut, psel, pen, pwr, slow, paddr, pwd} = '0;
        {key_n, dsel} = 2'b11;
        seed = 32'h3ced;
        cyc(8);
        rst_n <= 1'b1;
        cyc(4);
        check("switch after reset", sw, 1);
        apb(0, rst_timer_pkg::CTRL_OFS, 0);
        check("ctrl reset", rd, rst_timer_pkg::CTRL_RESET);
        seed = lfsr(seed);
        apb(1, rst_timer_pkg::CTRL_OFS, seed | 32'h1);
        seed = lfsr(seed);
        apb(seed[0], {seed[7:4], 4'h8}, seed);
        check("unmapped error", e, 1);
        // Short press: hold flag cleared, no reset
        key_n <= 1'b0;
        cyc(10 + seed[4:0]);
        key_n <= 1'b1;
        cyc(100);
        check("short press", sw, 1);
        $display("done short press");
        // Long press with a slow rail
        slow <= 1'b1;
        key_n <= 1'b0;
        cyc(55);
        check("before hold end", sw, 1);
        cyc(15);
        check("pulse switch", sw, 0);
        check("pulse pull-down", den, 1);
        key_n <= 1'b1;
        apb(0, rst_timer_pkg::STATUS_OFS, 0);
        check("status in pulse", {rd[rst_timer_pkg::ST_DISCH_BIT], rd[rst_timer_pkg::ST_SWITCH_BIT]}, 2'b10);
        cyc(40);
        check("wait discharge", sw, 0);
        check("pull-down after pulse", den, 0);
        slow <= 1'b0;
        cyc(30);
        check("reconnect", sw, 1);
        $display("done reset");
        // Long turn-off aborted by wake and key press at once, then repeated
        shut <= 1'b1;
        cyc(20);
        seed = lfsr(seed);
        wake <= seed[2];  // Abort by wake and key press together; seed[2] clear drives neither
        key_n <= ~seed[2];
        cyc(5);
        wake <= 1'b0;
        key_n <= 1'b1;
        cyc(80);
        check("aborted turn-off", sw, 1);
        shut <= 1'b0;
        cyc(5);
        shut <= 1'b1;
        cyc(30);
        check("turn-off counting", sw, 1);
        cyc(40);
        check("turn-off done", sw, 0);
        shut <= 1'b0;
        $display("done turn-off");
        // Power-on by key, held on without reset
        key_n <= 1'b0;
        cyc(35);
        check("before turn-on", sw, 0);
        cyc(15);
        check("turn-on", sw, 1);
        cyc(100);
        check("held key no reset", sw, 1);
        key_n <= 1'b1;
        dsel <= 1'b0;
        cyc(10);
        shut <= 1'b1;
        cyc(10);
        check("zero-second early", sw, 1);
        cyc(20);
        check("zero-second off", sw, 0);
        shut <= 1'b0;
        key_n <= 1'b0;
        cyc(20);
        check("fast turn-on", sw, 1);
        key_n <= 1'b1;
        cyc(5);
        key_n <= 1'b0;
        cyc(20);
        check("fast reset", sw, 0);
        key_n <= 1'b1;
        seed = lfsr(seed);
        slow <= seed[1];  // Rail may stay charged past the pulse
        cyc(40);
        check("fast reconnect", sw, !slow);
        slow <= 1'b0;
        cyc(10);
        check("late reconnect", sw, 1);
        $display("done fast modes");
        final_report();
    end
endmodule
